// File: src/pwr_cfg.svh
`ifndef PWR_CFG_SVH
`define PWR_CFG_SVH
// =====================================================
// Register byte offsets
`define OFF_PARALLEL_CFG 12'h004
`define OFF_SERIAL_PWR_CFG 12'h008
`define OFF_AUTO_PWR_CFG 12'h01c
`define OFF_PP_MODE 12'h020
`define OFF_STATUS 12'h024
`define OFF_IRQ_STAT 12'h028
`define OFF_IRQ_MASK 12'h02c
`define OFF_FDC_PWR 12'h030
// =====================================================
// Field positions
`define BIT_PP_PWR 2
`define BIT_UART1_PWR 3
`define BIT_UART2_PWR 7
`define BIT_AUTO_PP 4
`define BIT_AUTO_U1 5
`define BIT_AUTO_U2 6
// =====================================================
// Reset values
`define RST_PARALLEL_CFG 8'h9c
`define RST_SERIAL_PWR_CFG 8'h88
`define RST_AUTO_PWR_CFG 8'h00
// =====================================================
// Ecr mode encodings
`define ECR_SPP 3'h0
`define ECR_PS2 3'h1
`define ECR_EPP 3'h4
`endif

// File: src/pwr_pkg.sv
package pwr_pkg;
  typedef enum logic [1:0] {
    PD_ACTIVE = 2'b00,
    PD_ARMED = 2'b01,
    PD_DOWN = 2'b11
  } pd_state_e;

  typedef struct packed {
    logic thr_empty;
    logic tsr_empty;
    logic rx_fifo_empty;
    logic rx_idle;
    logic tx_write;
  } uart_stat_s;

  typedef struct packed {
    logic [3:0] spindle_on_out;
    logic [3:0] unit_select_out;
    logic write_stream_out;
    logic write_gate_out;
  } fdd_float_s;
endpackage

// File: src/uart_pd.sv
`timescale 1ns/1ns
module uart_pd (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic direct_pd,
  input wire logic auto_en,
  input wire pwr_pkg::uart_stat_s st,
  input wire logic rx_line_sync,
  output logic tx_down_ff,
  output logic rx_down_ff
);
  logic rx_last_ff;
  logic rx_edge;

  assign rx_edge = rx_line_sync ^ rx_last_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_last_ff <= 1'b1;
    end else begin
      rx_last_ff <= rx_line_sync;
    end
  end

  // Transmitter: host write wins over entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_down_ff <= 1'b0;
    end else if (direct_pd) begin
      tx_down_ff <= 1'b1;
    end else if (!auto_en || st.tx_write) begin
      tx_down_ff <= 1'b0;
    end else if (st.thr_empty && st.tsr_empty) begin
      tx_down_ff <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_down_ff <= 1'b0;
    end else if (direct_pd) begin
      rx_down_ff <= 1'b1;
    end else if (!auto_en || rx_edge) begin
      rx_down_ff <= 1'b0;
    end else if (st.rx_fifo_empty && st.rx_idle) begin
      rx_down_ff <= 1'b1;
    end
  end

  tx_wake_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !direct_pd && st.tx_write |=> !tx_down_ff)
    else $error("tx stayed down after a write");
  rx_wake_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !direct_pd && rx_edge |=> !rx_down_ff)
    else $error("rx stayed down after line change");
endmodule

// File: src/pp_pd.sv
`timescale 1ns/1ns
`include "pwr_cfg.svh"
module pp_pd (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic auto_en,
  input wire logic epp_cfg,
  input wire logic ecp_cfg,
  input wire logic [2:0] ecr_mode,
  output logic epp_down_ff,
  output logic ecp_down_ff,
  output logic reeval_ff
);
  logic [4:0] last_ff;
  logic nxt_epp;
  logic nxt_ecp;

  // Ecr mode is meaningful only when the ecp personality is enabled
  always_comb begin
    nxt_epp = auto_en && (!epp_cfg ||
      (ecp_cfg && ecr_mode != `ECR_EPP));
    nxt_ecp = auto_en && (!ecp_cfg || ecr_mode == `ECR_SPP ||
      ecr_mode == `ECR_PS2 || ecr_mode == `ECR_EPP);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      epp_down_ff <= 1'b0;
      ecp_down_ff <= 1'b0;
      last_ff <= 5'h00;
      reeval_ff <= 1'b0;
    end else begin
      epp_down_ff <= nxt_epp;
      ecp_down_ff <= nxt_ecp;
      last_ff <= {epp_cfg, ecp_cfg, ecr_mode};
      reeval_ff <= last_ff != {epp_cfg, ecp_cfg, ecr_mode};
    end
  end

  mode_follow_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $changed(ecr_mode) && auto_en && epp_cfg && ecp_cfg
    |=> epp_down_ff == ($past(ecr_mode) != `ECR_EPP))
    else $error("parallel powerdown not re-evaluated");
endmodule

// File: src/peripheral_auto_powerdown.sv
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "pwr_cfg.svh"
module peripheral_auto_powerdown (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire pwr_pkg::uart_stat_s uart1_stat,
  input wire pwr_pkg::uart_stat_s uart2_stat,
  input wire logic [1:0] serial_in_line,
  input wire logic [1:0] call_alert_input,
  input wire logic [2:0] ecr_mode,
  input wire logic fdc_pd_req,
  input wire pwr_pkg::fdd_float_s fdd_core,
  input wire logic [5:0] fdd_active_core,
  output pwr_pkg::fdd_float_s fdd_pin_out,
  output logic [9:0] fdd_pin_oe,
  output logic [5:0] fdd_active_out,
  output logic fdd_in_enable,
  output logic [1:0] uart_tx_down,
  output logic [1:0] uart_rx_down,
  output logic epp_down,
  output logic ecp_down,
  output logic pp_down
);
  // =====================================================
  // Registers
  logic [7:0] parallel_config_reg_ff;
  logic [7:0] serial_power_config_reg_ff;
  logic [7:0] auto_power_config_reg_ff;
  logic [1:0] pp_mode_ff;
  logic fdc_pd_ff;
  logic [3:0] irq_stat_ff;
  logic [3:0] irq_mask_ff;
  logic [3:0] nxt_irq_stat;
  logic [3:0] irq_event;
  logic [1:0] ri_s1_ff;
  logic [1:0] ri_s2_ff;
  logic [1:0] ri_last_ff;
  logic [1:0] rx_s1_ff;
  logic [1:0] rx_s2_ff;
  logic [1:0] tx_dn;
  logic [1:0] rx_dn;
  logic epp_dn;
  logic ecp_dn;
  logic reeval;
  logic pp_dn_prev_ff;
  logic wr_en;
  logic rd_en;
  logic [31:0] nxt_prdata;
  logic mapped;
  logic fdd_down;
  pwr_pkg::pd_state_e fdd_state_ff;

  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && !penable && !pwrite;

  // =====================================================
  // Bus slave
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      `OFF_PARALLEL_CFG: nxt_prdata = {24'h0, parallel_config_reg_ff};
      `OFF_SERIAL_PWR_CFG: nxt_prdata = {24'h0, serial_power_config_reg_ff};
      `OFF_AUTO_PWR_CFG: nxt_prdata = {24'h0, auto_power_config_reg_ff};
      `OFF_PP_MODE: nxt_prdata = {30'h0, pp_mode_ff};
      `OFF_STATUS: nxt_prdata = {24'h0, fdd_down, pp_dn_prev_ff, epp_dn,
        ecp_dn, rx_dn, tx_dn};
      `OFF_IRQ_STAT: nxt_prdata = {28'h0, irq_stat_ff};
      `OFF_IRQ_MASK: nxt_prdata = {28'h0, irq_mask_ff};
      `OFF_FDC_PWR: nxt_prdata = {31'h0, fdc_pd_ff};
      default: mapped = 1'b0;
    endcase
  end

  // No wait state; read data is registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (rd_en) begin
        prdata <= nxt_prdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parallel_config_reg_ff <= `RST_PARALLEL_CFG;
      serial_power_config_reg_ff <= `RST_SERIAL_PWR_CFG;
      auto_power_config_reg_ff <= `RST_AUTO_PWR_CFG;
      pp_mode_ff <= 2'h0;
      irq_mask_ff <= 4'h0;
      fdc_pd_ff <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        `OFF_PARALLEL_CFG: parallel_config_reg_ff <= pwdata[7:0];
        `OFF_SERIAL_PWR_CFG: serial_power_config_reg_ff <= pwdata[7:0];
        `OFF_AUTO_PWR_CFG: auto_power_config_reg_ff <= pwdata[7:0];
        `OFF_PP_MODE: pp_mode_ff <= pwdata[1:0];
        `OFF_IRQ_MASK: irq_mask_ff <= pwdata[3:0];
        `OFF_FDC_PWR: fdc_pd_ff <= pwdata[0];
        default: ;
      endcase
    end
  end

  // =====================================================
  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ri_s1_ff <= 2'h0;
      ri_s2_ff <= 2'h0;
      ri_last_ff <= 2'h0;
      rx_s1_ff <= 2'h3;
      rx_s2_ff <= 2'h3;
    end else begin
      ri_s1_ff <= call_alert_input;
      ri_s2_ff <= ri_s1_ff;
      ri_last_ff <= ri_s2_ff;
      rx_s1_ff <= serial_in_line;
      rx_s2_ff <= rx_s1_ff;
    end
  end

  // =====================================================
  // Serial ports
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_uart
      uart_pd u_pd (
        .pclk(pclk),
        .presetn(presetn),
        .direct_pd(serial_power_config_reg_ff[gi ? `BIT_UART2_PWR :
          `BIT_UART1_PWR]),
        .auto_en(auto_power_config_reg_ff[gi ? `BIT_AUTO_U2 :
          `BIT_AUTO_U1]),
        .st(gi ? uart2_stat : uart1_stat),
        .rx_line_sync(rx_s2_ff[gi]),
        .tx_down_ff(tx_dn[gi]),
        .rx_down_ff(rx_dn[gi])
      );
      // Ring change is reported whatever the power state
      assign irq_event[gi] = ri_s2_ff[gi] ^ ri_last_ff[gi];
    end
  endgenerate

  // =====================================================
  // Parallel port
  pp_pd u_pp (
    .pclk(pclk),
    .presetn(presetn),
    .auto_en(auto_power_config_reg_ff[`BIT_AUTO_PP]),
    .epp_cfg(pp_mode_ff[0]),
    .ecp_cfg(pp_mode_ff[1]),
    .ecr_mode(ecr_mode),
    .epp_down_ff(epp_dn),
    .ecp_down_ff(ecp_dn),
    .reeval_ff(reeval)
  );

  assign irq_event[2] = reeval;
  assign irq_event[3] = fdd_down && fdd_state_ff != pwr_pkg::PD_DOWN;

  // =====================================================
  // Interrupt status, set wins over write-one-clear
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (wr_en && paddr == `OFF_IRQ_STAT) begin
      nxt_irq_stat = irq_stat_ff & ~pwdata[3:0];
    end
    nxt_irq_stat = nxt_irq_stat | irq_event;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

  // =====================================================
  // Floppy pin states
  assign fdd_down = fdc_pd_ff || fdc_pd_req;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fdd_state_ff <= pwr_pkg::PD_ACTIVE;
    end else begin
      case (fdd_state_ff)
        pwr_pkg::PD_ACTIVE: fdd_state_ff <= fdd_down ?
          pwr_pkg::PD_DOWN : pwr_pkg::PD_ACTIVE;
        pwr_pkg::PD_DOWN: fdd_state_ff <= fdd_down ?
          pwr_pkg::PD_DOWN : pwr_pkg::PD_ACTIVE;
        default: fdd_state_ff <= pwr_pkg::PD_ACTIVE;
      endcase
    end
  end

  // Floated pins keep following the core values so waking needs no reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fdd_pin_out <= '0;
      fdd_pin_oe <= 10'h000;
      fdd_active_out <= 6'h00;
      fdd_in_enable <= 1'b1;
    end else begin
      fdd_pin_out <= fdd_core;
      fdd_pin_oe <= fdd_down ? 10'h000 : 10'h3ff;
      fdd_active_out <= fdd_active_core;
      fdd_in_enable <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uart_tx_down <= 2'h0;
      uart_rx_down <= 2'h0;
      epp_down <= 1'b0;
      ecp_down <= 1'b0;
      pp_down <= 1'b0;
      pp_dn_prev_ff <= 1'b0;
    end else begin
      uart_tx_down <= tx_dn;
      uart_rx_down <= rx_dn;
      epp_down <= epp_dn || parallel_config_reg_ff[`BIT_PP_PWR];
      ecp_down <= ecp_dn || parallel_config_reg_ff[`BIT_PP_PWR];
      pp_down <= parallel_config_reg_ff[`BIT_PP_PWR];
      pp_dn_prev_ff <= parallel_config_reg_ff[`BIT_PP_PWR];
    end
  end

  // =====================================================
  // Checks
  sequence ri_change_s;
    ri_s2_ff[0] != ri_last_ff[0];
  endsequence
  sequence ri_change_two_s;
    ri_s2_ff[1] != ri_last_ff[1];
  endsequence
  sequence irq_hold_s;
    irq_stat_ff[0] && irq_mask_ff[0] &&
      !(wr_en && paddr == `OFF_IRQ_STAT && pwdata[0]);
  endsequence
  sequence pp_mode_wr_s;
    wr_en && paddr == `OFF_PP_MODE && pwdata[1:0] != pp_mode_ff;
  endsequence

  ri_live_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ri_change_s |=> irq_stat_ff[0])
    else $error("ring change lost");

  ri_two_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ri_change_two_s |=> irq_stat_ff[1])
    else $error("ring change on port two lost");

  irq_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_hold_s |=> irq)
    else $error("irq low with unmasked ring status");

  mode_reeval_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pp_mode_wr_s |=> ##1 reeval)
    else $error("mode change not re-evaluated");

  fdd_float_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    fdd_down |=> fdd_pin_oe == 10'h000)
    else $error("drive pins driven in powerdown");

  fdd_wake_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !fdd_down |=> fdd_pin_oe == 10'h3ff)
    else $error("drive pins floated while awake");

  fdd_active_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> fdd_active_out == $past(fdd_active_core))
    else $error("active pins stopped");

  fdd_inputs_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    fdd_down |=> fdd_in_enable)
    else $error("drive inputs disabled in powerdown");

  pp_direct_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    parallel_config_reg_ff[`BIT_PP_PWR] |=> pp_down && epp_down && ecp_down)
    else $error("direct parallel powerdown ignored");

  auto_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !auto_power_config_reg_ff[`BIT_AUTO_PP] |=> !epp_dn && !ecp_dn)
    else $error("parallel down without auto enable");

  epp_auto_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    auto_power_config_reg_ff[`BIT_AUTO_PP] && !pp_mode_ff[0] |=> epp_dn)
    else $error("epp awake while not enabled");

  ecp_auto_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    auto_power_config_reg_ff[`BIT_AUTO_PP] && !pp_mode_ff[1] |=> ecp_dn)
    else $error("ecp awake while not enabled");

  tx_direct_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    serial_power_config_reg_ff[`BIT_UART1_PWR] |=> tx_dn[0])
    else $error("uart1 direct powerdown ignored");

  tx_two_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    serial_power_config_reg_ff[`BIT_UART2_PWR] |=> tx_dn[1] && rx_dn[1])
    else $error("uart2 direct powerdown ignored");
endmodule

// File: verification/far_side.sv
`timescale 1ns/1ns
// =====================================================
// Drive cable, serial lines and ring lines
module far_side (
  input wire logic pclk,
  input wire logic [1:0] rx_flip,
  input wire logic [1:0] ring_flip,
  input wire pwr_pkg::fdd_float_s fdd_pin_out,
  input wire logic [9:0] fdd_pin_oe,
  output logic [1:0] serial_in_line,
  output logic [1:0] call_alert_input,
  output logic [9:0] fdd_wire
);
  // Serial lines rest at mark; a flip request is one edge on the wire
  initial begin
    serial_in_line = 2'h3;
    call_alert_input = 2'h0;
  end
  always @(posedge pclk) begin
    serial_in_line <= serial_in_line ^ rx_flip;
    call_alert_input <= call_alert_input ^ ring_flip;
  end
  // Cable pull-ups: a floated pin must read high, never the last value
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      fdd_wire[i] = fdd_pin_oe[i] ? fdd_pin_out[i] : 1'b1;
    end
  end
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ns
`include "pwr_cfg.svh"
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, x;
  pwr_pkg::uart_stat_s u1, u2;
  pwr_pkg::fdd_float_s fdd_core, fdd_pin_out;
  logic [1:0] sil, cai, rx_flip, ring_flip, uart_tx_down, uart_rx_down;
  logic [2:0] ecr_mode;
  logic fdc_pd_req, fdd_in_enable, epp_down, ecp_down, pp_down;
  logic [5:0] fdd_active_core, fdd_active_out;
  logic [9:0] fdd_pin_oe, fdd_wire;
  int mismatches, checked, n;
  peripheral_auto_powerdown DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .uart1_stat(u1), .uart2_stat(u2), .serial_in_line(sil),
    .call_alert_input(cai), .ecr_mode(ecr_mode), .fdc_pd_req(fdc_pd_req),
    .fdd_core(fdd_core), .fdd_active_core(fdd_active_core),
    .fdd_pin_out(fdd_pin_out), .fdd_pin_oe(fdd_pin_oe),
    .fdd_active_out(fdd_active_out), .fdd_in_enable(fdd_in_enable),
    .uart_tx_down(uart_tx_down), .uart_rx_down(uart_rx_down),
    .epp_down(epp_down), .ecp_down(ecp_down), .pp_down(pp_down));
  far_side partner (.pclk(pclk), .rx_flip(rx_flip), .ring_flip(ring_flip),
    .fdd_pin_out(fdd_pin_out), .fdd_pin_oe(fdd_pin_oe),
    .serial_in_line(sil), .call_alert_input(cai), .fdd_wire(fdd_wire));
  // =====================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Writes settle for the flag pipeline before returning
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    cyc(5);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // =====================================================
  // Scenarios
  task automatic t_reset();
    rd(`OFF_PARALLEL_CFG, 32'h9c);
    rd(`OFF_SERIAL_PWR_CFG, 32'h88);
    rd(`OFF_AUTO_PWR_CFG, 32'h0);
    rd(`OFF_STATUS, 32'h4f);
    chk({pp_down, uart_tx_down, uart_rx_down}, 32'h1f);
  endtask
  task automatic t_direct();
    logic [7:0] cfg [3] = '{8'h08, 8'h80, 8'h00};
    logic [1:0] ex [3] = '{2'h1, 2'h2, 2'h0};
    for (int i = 0; i < 3; i++) begin
      wr(`OFF_SERIAL_PWR_CFG, {24'h0, cfg[i]});
      chk({uart_tx_down, uart_rx_down}, {ex[i], ex[i]});
    end
    wr(`OFF_PARALLEL_CFG, 32'h98);
    chk(pp_down, 32'h0);
    wr(`OFF_PARALLEL_CFG, 32'h9c);
    chk(pp_down, 32'h1);
  endtask
  task automatic t_uart();
    u1 <= 5'h14;
    u2 <= 5'h14;
    wr(`OFF_AUTO_PWR_CFG, 32'h60);
    rd(`OFF_AUTO_PWR_CFG, 32'h60);
    chk({uart_tx_down, uart_rx_down}, 32'h0);
    u1 <= 5'h1e;
    u2 <= 5'h1e;
    cyc(5);
    chk({uart_tx_down, uart_rx_down}, 32'hf);
    wr(`OFF_AUTO_PWR_CFG, 32'h20);
    chk({uart_tx_down, uart_rx_down}, 32'h5);
    wr(`OFF_AUTO_PWR_CFG, 32'h40);
    chk({uart_tx_down, uart_rx_down}, 32'ha);
    wr(`OFF_AUTO_PWR_CFG, 32'h60);
    u1 <= 5'h0f;
    rx_flip <= 2'h1;
    cyc(1);
    u1 <= 5'h0e;
    rx_flip <= 2'h0;
    n = 0;
    while (uart_rx_down[0] !== 1'b0 && n < 8) begin
      cyc(1);
      n++;
    end
    chk(uart_rx_down[0], 32'h0);
    cyc(3);
    chk(uart_tx_down, 32'h2);
    wr(`OFF_AUTO_PWR_CFG, 32'h0);
    chk({uart_tx_down, uart_rx_down}, 32'h0);
  endtask
  task automatic t_ring();
    wr(`OFF_SERIAL_PWR_CFG, 32'h88);
    wr(`OFF_IRQ_STAT, 32'hf);
    for (int k = 0; k < 4; k++) begin
      // Mask on for port one only; both edges of each line count
      wr(`OFF_IRQ_MASK, 32'h1);
      ring_flip <= (k < 2) ? 2'h1 : 2'h2;
      cyc(1);
      ring_flip <= 2'h0;
      cyc(6);
      rd(`OFF_IRQ_STAT, (k < 2) ? 32'h1 : 32'h2);
      chk(irq, (k < 2) ? 32'h1 : 32'h0);
      wr(`OFF_IRQ_STAT, 32'h3);
      chk(irq, 32'h0);
    end
  endtask
  task automatic t_pp();
    wr(`OFF_PARALLEL_CFG, 32'h98);
    wr(`OFF_PP_MODE, 32'h3);
    wr(`OFF_AUTO_PWR_CFG, 32'h10);
    for (int e = 0; e < 8; e++) begin
      ecr_mode <= 3'(e);
      cyc(4);
      x = {30'h0, e != `ECR_EPP,
           e == `ECR_SPP || e == `ECR_PS2 || e == `ECR_EPP};
      chk({epp_down, ecp_down}, x);
    end
    rd(`OFF_IRQ_STAT, 32'h4);
    wr(`OFF_IRQ_STAT, 32'h4);
    ecr_mode <= 3'h3;
    wr(`OFF_PP_MODE, 32'h1);
    chk({epp_down, ecp_down}, 32'h1);
    wr(`OFF_PP_MODE, 32'h2);
    chk({epp_down, ecp_down}, 32'h2);
    rd(`OFF_IRQ_STAT, 32'h4);
    wr(`OFF_AUTO_PWR_CFG, 32'h0);
    chk({epp_down, ecp_down}, 32'h0);
  endtask
  task automatic t_fdd();
    fdd_core <= 10'h0a5;
    fdd_active_core <= 6'h2b;
    wr(`OFF_IRQ_STAT, 32'hf);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) begin
        wr(`OFF_FDC_PWR, 32'h1);
      end else begin
        fdc_pd_req <= 1'b1;
        cyc(5);
      end
      chk(fdd_pin_oe, 32'h0);
      chk(fdd_wire, 32'h3ff);
      chk(fdd_active_out, 32'h2b);
      chk(fdd_in_enable, 32'h1);
      rd(`OFF_IRQ_STAT, 32'h8);
      wr(`OFF_IRQ_STAT, 32'h8);
      wr(`OFF_FDC_PWR, 32'h0);
      fdc_pd_req <= 1'b0;
      cyc(5);
      chk(fdd_pin_oe, 32'h3ff);
      chk(fdd_wire, 32'h0a5);
    end
  endtask
  task automatic t_bad();
    apb(1'b0, 12'h3fc, 32'h0);
    chk(err, 32'h1);
    chk(q, 32'h0);
  endtask
  // =====================================================
  // Verdict
  task automatic results();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Whole run needs about 4 us; fifty times that means a hang
  initial begin
    #200000;
    mismatches++;
    results();
  end
  initial begin
    {presetn, psel, penable, pwrite, fdc_pd_req} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    u1 = 5'h14;
    u2 = 5'h14;
    rx_flip = 2'h0;
    ring_flip = 2'h0;
    ecr_mode = 3'h0;
    fdd_core = 10'h0;
    fdd_active_core = 6'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_direct();
    t_uart();
    t_ring();
    t_pp();
    t_fdd();
    t_bad();
    results();
  end
endmodule
